// File: design/feprd_top.sv
`timescale 1ns/10ps
module feprd_top #(
  parameter int LOCK_BITS = feprd_pkg::DSC_LOCK_BITS
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic [4:0] ADDR,
  input wire logic [15:0] WR_DATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  output logic [15:0] RD_DATA,
  input wire logic RX_LCLK,
  input wire logic RX_LDATA,
  input wire logic SIG_DET,
  input wire logic NLP_SEEN,
  input wire logic MLT3_SEEN,
  input wire logic FLP_SEEN,
  input wire logic [3:0] LP_ABIL,
  input wire logic LP_VALID,
  input wire logic TX_EN,
  input wire logic [3:0] TXD,
  input wire logic TX_STB,
  output logic [3:0] RXD,
  output logic RX_DV,
  output logic RX_ER,
  output logic RX_STB,
  output logic COL,
  output logic CRS,
  output logic TX_LINE,
  output logic TX_TAKE,
  output logic FLP_EMIT,
  output logic LINK_UP,
  output logic AN_ACK
);
  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [5:0] s1_r, s2_r;
  logic lclk_d_r;
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      s1_r <= 6'h00;
      s2_r <= 6'h00;
      lclk_d_r <= 1'b0;
    end else begin
      s1_r <= {RX_LCLK, RX_LDATA, SIG_DET, NLP_SEEN, MLT3_SEEN, FLP_SEEN};
      s2_r <= s1_r;
      lclk_d_r <= s2_r[5];
    end
  end
  wire lrise = s2_r[5] && !lclk_d_r;
  wire ldata = s2_r[4];
  wire sig = s2_r[3];
  wire nlp = s2_r[2];
  wire mlt3 = s2_r[1];
  wire flp = s2_r[0];
  wire any_sig = sig || nlp || mlt3 || flp;

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [15:0] ctrl_r, pwr_r;
  logic [3:0] adv_r, lpa_r;
  logic pr_r, link_r;
  logic [1:0] res_r;
  feprd_pkg::feprd_an_t an_r;
  feprd_pkg::feprd_aln_t aln_r;
  logic locked;
  wire wr_ctrl = WR_STB && (ADDR == feprd_pkg::REG_CTRL);
  wire wr_adv = WR_STB && (ADDR == feprd_pkg::REG_ADV);
  wire wr_pwr = WR_STB && (ADDR == feprd_pkg::REG_PWR);
  wire pd = ctrl_r[feprd_pkg::CTRL_PD];
  wire an_en = ctrl_r[feprd_pkg::CTRL_AN];
  wire pre_en = pwr_r[feprd_pkg::PWR_PRE];
  wire act = !pd && !pr_r;
  wire spd100 = an_en ? res_r[1] : ctrl_r[feprd_pkg::CTRL_SPD];
  wire full_dx = an_en ? res_r[0] : ctrl_r[feprd_pkg::CTRL_FD];
  wire en100 = act && spd100;
  wire en10 = act && !spd100;
  wire [15:0] stat = {9'h000, full_dx, spd100, an_r == feprd_pkg::AN_FAIL,
    an_r == feprd_pkg::AN_LINK, locked, pr_r, link_r};
  wire [15:0] rd_mux = (ADDR == feprd_pkg::REG_CTRL) ? ctrl_r :
    (ADDR == feprd_pkg::REG_STAT) ? stat :
    (ADDR == feprd_pkg::REG_ADV) ? {12'h000, adv_r} :
    (ADDR == feprd_pkg::REG_LPA) ? {12'h000, lpa_r} :
    (ADDR == feprd_pkg::REG_PWR) ? pwr_r : 16'h0000;
  // The management port runs regardless of power-down so software can wake the block.
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ctrl_r <= feprd_pkg::CTRL_RST;
      adv_r <= feprd_pkg::ADV_RST;
      pwr_r <= feprd_pkg::PWR_RST;
      RD_DATA <= 16'h0000;
    end else begin
      if (wr_ctrl) ctrl_r <= WR_DATA & 16'h3900;
      if (wr_adv) adv_r <= WR_DATA[3:0];
      if (wr_pwr) pwr_r <= WR_DATA & feprd_pkg::PWR_RST;
      RD_DATA <= RD_STB ? rd_mux : 16'h0000;
    end
  end

  // ------------------------------------------------------------
  // Power-reduced state
  // ------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      pr_r <= 1'b0;
      FLP_EMIT <= 1'b0;
    end else begin
      pr_r <= !pd && pre_en && !any_sig;
      FLP_EMIT <= !pd && (pr_r || (an_en && an_r != feprd_pkg::AN_LINK));
    end
  end

  // ------------------------------------------------------------
  // Auto-negotiation and parallel detection
  // ------------------------------------------------------------
  wire [3:0] common = adv_r & LP_ABIL;
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      an_r <= feprd_pkg::AN_WAIT;
      res_r <= 2'h0;
      lpa_r <= 4'h0;
      AN_ACK <= 1'b0;
    end else if (!an_en || !act || wr_ctrl) begin
      an_r <= feprd_pkg::AN_WAIT;
      AN_ACK <= 1'b0;
    end else begin
      case (an_r)
        feprd_pkg::AN_WAIT: begin
          if (LP_VALID) begin
            lpa_r <= LP_ABIL;
            AN_ACK <= 1'b1;
            if (common != 4'h0) begin
              res_r <= feprd_pkg::feprd_best(common);
              an_r <= feprd_pkg::AN_LINK;
            end else begin
              an_r <= feprd_pkg::AN_FAIL;
            end
          end else if (mlt3 && adv_r[2]) begin
            res_r <= 2'h2;
            an_r <= feprd_pkg::AN_LINK;
          end else if (nlp && adv_r[0]) begin
            res_r <= 2'h0;
            an_r <= feprd_pkg::AN_LINK;
          end
        end
        feprd_pkg::AN_LINK: begin
          if (!sig && !nlp && !mlt3) begin
            an_r <= feprd_pkg::AN_WAIT;
            AN_ACK <= 1'b0;
          end
        end
        feprd_pkg::AN_FAIL: begin
          if (LP_VALID) begin
            an_r <= feprd_pkg::AN_WAIT;
            AN_ACK <= 1'b0;
          end
        end
        default: an_r <= feprd_pkg::AN_WAIT;
      endcase
    end
  end

  // ------------------------------------------------------------
  // 100 Mb/s: NRZI to NRZ, deserialiser, descrambler
  // ------------------------------------------------------------
  logic nrzi_prev_r, wstb_r;
  logic [4:0] sh_r, word_r;
  logic [2:0] bcnt_r;
  logic [4:0] plain;
  logic plain_stb;
  wire nrz = ldata ^ nrzi_prev_r;
  always_ff @(posedge SYS_CLK) begin
    if (RST || !en100) begin
      nrzi_prev_r <= 1'b0;
      sh_r <= 5'h00;
      bcnt_r <= 3'h0;
      word_r <= 5'h00;
      wstb_r <= 1'b0;
    end else begin
      wstb_r <= 1'b0;
      if (lrise) begin
        nrzi_prev_r <= ldata;
        sh_r <= {sh_r[3:0], nrz};
        bcnt_r <= (bcnt_r == 3'h4) ? 3'h0 : bcnt_r + 3'h1;
        if (bcnt_r == 3'h4) begin
          word_r <= {sh_r[3:0], nrz};
          wstb_r <= 1'b1;
        end
      end
    end
  end
  feprd_desc #(.LOCK_BITS(LOCK_BITS)) u_desc (
    .clk(SYS_CLK),
    .rst(RST),
    .en(en100),
    .word_stb(wstb_r),
    .word(word_r),
    .plain(plain),
    .plain_stb(plain_stb),
    .locked(locked)
  );

  // ------------------------------------------------------------
  // 100 Mb/s: alignment and 4B5B decoding
  // ------------------------------------------------------------
  logic [9:0] hist_r;
  logic [2:0] off_r, jk_off;
  logic jk_hit;
  logic [4:0] pend_r;
  logic pend_v_r;
  logic [1:0] pre_cnt_r;
  feprd_pkg::feprd_nib_t e100_r;
  logic e100_stb_r;
  wire [14:0] h15 = {hist_r, plain};
  wire [4:0] grp = 5'(h15 >> off_r);
  wire [4:0] pdec = feprd_pkg::feprd_dec5b(pend_r);
  wire end_pair = pend_v_r && (pend_r == feprd_pkg::CG_T) && (grp == feprd_pkg::CG_R);
  always_comb begin
    jk_hit = 1'b0;
    jk_off = 3'h0;
    for (int o = 4; o >= 0; o--) begin
      if (h15[o +: 10] == {feprd_pkg::CG_J, feprd_pkg::CG_K}) begin
        jk_hit = 1'b1;
        jk_off = 3'(o);
      end
    end
  end
  // A frame that stops in idle without T/R is closed silently; idle never decodes.
  always_ff @(posedge SYS_CLK) begin
    if (RST || !en100) begin
      hist_r <= 10'h000;
      off_r <= 3'h0;
      aln_r <= feprd_pkg::ALN_HUNT;
      pend_r <= 5'h00;
      pend_v_r <= 1'b0;
      pre_cnt_r <= 2'h0;
      e100_r <= '0;
      e100_stb_r <= 1'b0;
    end else begin
      e100_stb_r <= 1'b0;
      if (pre_cnt_r != 2'h0) begin
        pre_cnt_r <= pre_cnt_r - 2'h1;
        e100_r <= '{dv: 1'b1, er: 1'b0, nib: feprd_pkg::PRE_NIB};
        e100_stb_r <= 1'b1;
      end
      if (plain_stb) begin
        hist_r <= h15[9:0];
        case (aln_r)
          feprd_pkg::ALN_HUNT: begin
            if (jk_hit) begin
              aln_r <= feprd_pkg::ALN_FRAME;
              off_r <= jk_off;
              pre_cnt_r <= 2'h2;
              pend_v_r <= 1'b0;
            end
          end
          feprd_pkg::ALN_FRAME: begin
            if (end_pair || grp == feprd_pkg::CG_I) begin
              aln_r <= feprd_pkg::ALN_HUNT;
              pend_v_r <= 1'b0;
              e100_r <= '0;
            end else begin
              pend_r <= grp;
              pend_v_r <= 1'b1;
              if (pend_v_r) begin
                e100_r <= '{dv: 1'b1, er: !pdec[4], nib: pdec[3:0]};
                e100_stb_r <= 1'b1;
              end
            end
          end
          default: aln_r <= feprd_pkg::ALN_HUNT;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // 10 Mb/s Manchester path
  // ------------------------------------------------------------
  feprd_pkg::feprd_nib_t n10;
  logic n10_stb, tx10_take, tx10_line;
  feprd_man10 u_man10 (
    .clk(SYS_CLK),
    .rst(RST),
    .en(en10),
    .hb_stb(lrise),
    .hb_val(ldata),
    .rx_act(sig),
    .tx_en(TX_EN),
    .txd(TXD),
    .tx_stb(TX_STB),
    .rx_nib(n10),
    .rx_stb(n10_stb),
    .tx_take(tx10_take),
    .tx_line(tx10_line)
  );

  // ------------------------------------------------------------
  // MII side outputs, collision and carrier sense
  // ------------------------------------------------------------
  wire rx_act = spd100 ? (aln_r == feprd_pkg::ALN_FRAME) : sig;
  wire tx_act = TX_EN;
  feprd_pkg::feprd_nib_t nsel;
  assign nsel = spd100 ? e100_r : n10;
  wire nsel_stb = spd100 ? e100_stb_r : n10_stb;
  always_ff @(posedge SYS_CLK) begin
    if (RST || !act) begin
      RXD <= 4'h0;
      RX_DV <= 1'b0;
      RX_ER <= 1'b0;
      RX_STB <= 1'b0;
      COL <= 1'b0;
      CRS <= 1'b0;
      TX_LINE <= 1'b0;
      TX_TAKE <= 1'b0;
      LINK_UP <= 1'b0;
      link_r <= 1'b0;
    end else begin
      RX_STB <= nsel_stb;
      RX_DV <= rx_act && nsel.dv;
      RX_ER <= nsel_stb && nsel.er;
      if (nsel_stb) RXD <= nsel.nib;
      COL <= !full_dx && tx_act && rx_act;
      CRS <= rx_act || (!full_dx && tx_act);
      TX_LINE <= tx10_line;
      TX_TAKE <= tx10_take;
      link_r <= an_en ? (an_r == feprd_pkg::AN_LINK) : sig;
      LINK_UP <= an_en ? (an_r == feprd_pkg::AN_LINK) : sig;
    end
  end
endmodule // feprd_top

// File: design/feprd_pkg.sv
package feprd_pkg;
  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STAT = 5'h01;
  localparam logic [4:0] REG_ADV = 5'h04;
  localparam logic [4:0] REG_LPA = 5'h05;
  localparam logic [4:0] REG_PWR = 5'h10;
  localparam int CTRL_SPD = 13;
  localparam int CTRL_AN = 12;
  localparam int CTRL_PD = 11;
  localparam int CTRL_FD = 8;
  localparam logic [15:0] CTRL_RST = 16'h3000;
  localparam logic [3:0] ADV_RST = 4'hF;
  localparam int PWR_PRE = 4;
  localparam logic [15:0] PWR_RST = 16'h0010;
  // ------------------------------------------------------------
  // Code groups and timing
  // ------------------------------------------------------------
  localparam logic [4:0] CG_J = 5'h18;
  localparam logic [4:0] CG_K = 5'h11;
  localparam logic [4:0] CG_T = 5'h0D;
  localparam logic [4:0] CG_R = 5'h07;
  localparam logic [4:0] CG_I = 5'h1F;
  localparam logic [3:0] PRE_NIB = 4'h5;
  localparam int CLK_NS = 10;
  localparam int HALF_BIT_NS = 50;
  localparam int HALF_BIT_CYC = (HALF_BIT_NS / CLK_NS < 1) ? 1 : HALF_BIT_NS / CLK_NS;
  localparam int DSC_LOCK_BITS = 30;
  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef struct packed {
    logic dv;
    logic er;
    logic [3:0] nib;
  } feprd_nib_t;
  typedef enum logic {ALN_HUNT, ALN_FRAME} feprd_aln_t;
  typedef enum logic [1:0] {AN_WAIT, AN_LINK, AN_FAIL} feprd_an_t;
  // ------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------
  function automatic logic [4:0] feprd_dec5b(input logic [4:0] g);
    case (g)
      5'h1E: feprd_dec5b = 5'h10;
      5'h09: feprd_dec5b = 5'h11;
      5'h14: feprd_dec5b = 5'h12;
      5'h15: feprd_dec5b = 5'h13;
      5'h0A: feprd_dec5b = 5'h14;
      5'h0B: feprd_dec5b = 5'h15;
      5'h0E: feprd_dec5b = 5'h16;
      5'h0F: feprd_dec5b = 5'h17;
      5'h12: feprd_dec5b = 5'h18;
      5'h13: feprd_dec5b = 5'h19;
      5'h16: feprd_dec5b = 5'h1A;
      5'h17: feprd_dec5b = 5'h1B;
      5'h1A: feprd_dec5b = 5'h1C;
      5'h1B: feprd_dec5b = 5'h1D;
      5'h1C: feprd_dec5b = 5'h1E;
      5'h1D: feprd_dec5b = 5'h1F;
      default: feprd_dec5b = 5'h00;
    endcase
  endfunction
  // Abilities: bit0 10 half, bit1 10 full, bit2 100 half, bit3 100 full.
  function automatic logic [1:0] feprd_best(input logic [3:0] c);
    if (c[3]) feprd_best = 2'h3;
    else if (c[2]) feprd_best = 2'h2;
    else if (c[1]) feprd_best = 2'h1;
    else feprd_best = 2'h0;
  endfunction
endpackage

// File: design/feprd_desc.sv
`timescale 1ns/10ps
module feprd_desc #(
  parameter int LOCK_BITS = feprd_pkg::DSC_LOCK_BITS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic en,
  input wire logic word_stb,
  input wire logic [4:0] word,
  output logic [4:0] plain,
  output logic plain_stb,
  output logic locked
);
  logic [10:0] lfsr_r, lfsr_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [4:0] pl_nxt;
  // Until locked, the line is assumed idle, so each scrambled bit inverted is the key.
  always_comb begin
    logic k;
    k = 1'b0;
    lfsr_nxt = lfsr_r;
    cnt_nxt = cnt_r;
    pl_nxt = 5'h00;
    for (int i = 4; i >= 0; i--) begin
      k = lfsr_nxt[10] ^ lfsr_nxt[8];
      pl_nxt[i] = word[i] ^ k;
      if (!locked) begin
        cnt_nxt = (~word[i] == k) ? cnt_nxt + 8'h01 : 8'h00;
        k = ~word[i];
      end
      lfsr_nxt = {lfsr_nxt[9:0], k};
    end
  end
  always_ff @(posedge clk) begin
    if (rst || !en) begin
      lfsr_r <= 11'h000;
      cnt_r <= 8'h00;
      plain <= 5'h00;
      plain_stb <= 1'b0;
      locked <= 1'b0;
    end else begin
      plain_stb <= word_stb && locked;
      if (word_stb) begin
        lfsr_r <= lfsr_nxt;
        cnt_r <= cnt_nxt;
        plain <= pl_nxt;
        if (cnt_nxt >= 8'(LOCK_BITS)) locked <= 1'b1;
      end
    end
  end
endmodule // feprd_desc

// File: design/feprd_man10.sv
`timescale 1ns/10ps
module feprd_man10 (
  input wire logic clk,
  input wire logic rst,
  input wire logic en,
  input wire logic hb_stb,
  input wire logic hb_val,
  input wire logic rx_act,
  input wire logic tx_en,
  input wire logic [3:0] txd,
  input wire logic tx_stb,
  output feprd_pkg::feprd_nib_t rx_nib,
  output logic rx_stb,
  output logic tx_take,
  output logic tx_line
);
  logic first_v_r, first_r;
  logic [3:0] rsh_r;
  logic [1:0] rcnt_r;
  logic [3:0] tsh_r;
  logic [2:0] tleft_r;
  logic thalf_r;
  logic [7:0] div_r;
  wire tick = (div_r == 8'(feprd_pkg::HALF_BIT_CYC - 1));
  wire pair_ok = first_v_r && (first_r != hb_val);
  wire take = en && tx_en && tx_stb && (tleft_r == 3'h0);
  // Receive: a bit is a half-bit pair; a 1 goes low then high.
  always_ff @(posedge clk) begin
    if (rst || !en || !rx_act) begin
      first_v_r <= 1'b0;
      first_r <= 1'b0;
      rsh_r <= 4'h0;
      rcnt_r <= 2'h0;
      rx_stb <= 1'b0;
      rx_nib <= '0;
    end else begin
      rx_stb <= 1'b0;
      rx_nib.dv <= 1'b1;
      if (hb_stb) begin
        if (!first_v_r || !pair_ok) begin
          first_v_r <= 1'b1; // A violation slips by one half-bit to realign.
          first_r <= hb_val;
        end else begin
          first_v_r <= 1'b0;
          rsh_r <= {hb_val, rsh_r[3:1]};
          rcnt_r <= rcnt_r + 2'h1;
          if (rcnt_r == 2'h3) begin
            rx_stb <= 1'b1;
            rx_nib <= '{dv: 1'b1, er: 1'b0, nib: {hb_val, rsh_r[3:1]}};
          end
        end
      end
    end
  end
  // Transmit: nibble bits leave LSB first, two half-bits each.
  always_ff @(posedge clk) begin
    if (rst || !en) begin
      tsh_r <= 4'h0;
      tleft_r <= 3'h0;
      thalf_r <= 1'b0;
      div_r <= 8'h00;
      tx_take <= 1'b0;
      tx_line <= 1'b0;
    end else begin
      tx_take <= take;
      div_r <= tick ? 8'h00 : div_r + 8'h01;
      if (take) begin
        tsh_r <= txd;
        tleft_r <= 3'h4;
        thalf_r <= 1'b0;
      end else if (tick && tleft_r != 3'h0) begin
        tx_line <= thalf_r ? tsh_r[0] : ~tsh_r[0];
        thalf_r <= ~thalf_r;
        if (thalf_r) begin
          tsh_r <= {1'b0, tsh_r[3:1]};
          tleft_r <= tleft_r - 3'h1;
        end
      end else if (tleft_r == 3'h0 && !tx_en) begin
        tx_line <= 1'b0;
      end
    end
  end
endmodule // feprd_man10

// File: tb/feprd_properties.sv
`timescale 1ns/10ps
// ----------------------------------------
// Port checker for the receive decoder
// ----------------------------------------
module feprd_properties #(
  parameter int LOCK_BITS = 30
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic [4:0] ADDR,
  input wire logic [15:0] WR_DATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  input wire logic [15:0] RD_DATA,
  input wire logic TX_EN,
  input wire logic TX_STB,
  input wire logic RX_ER,
  input wire logic RX_STB,
  input wire logic COL,
  input wire logic CRS,
  input wire logic TX_TAKE,
  input wire logic LINK_UP
);
  logic [15:0] ctrl_r;
  wire logic fd;
  wire logic pd;
  // Only forced mode fixes the duplex from this bit; negotiation picks its own.
  assign fd = ctrl_r[8] && !ctrl_r[12];
  assign pd = ctrl_r[11];
  // The mode is rebuilt from bus writes, since the checker sees no internal state.
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ctrl_r <= 16'h3000;
    end else if (WR_STB && ADDR == 5'h00) begin
      ctrl_r <= WR_DATA & 16'h3900;
    end
  end
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RST);
  sequence s_offer;
    TX_EN && TX_STB;
  endsequence
  sequence s_quiet;
    !TX_TAKE [*8];
  endsequence
  property p_take_cause;
    TX_TAKE |-> $past(TX_EN, 2) && $past(TX_STB, 2);
  endproperty
  a_take_cause: assert property (p_take_cause) else $error("take without offer");
  property p_take_gap;
    s_offer ##2 TX_TAKE |=> s_quiet;
  endproperty
  a_take_gap: assert property (p_take_gap) else $error("nibbles taken too close");
  property p_rd_unmapped;
    $past(RD_STB) && !($past(ADDR) inside {5'h00, 5'h01, 5'h04, 5'h05, 5'h10})
      |-> RD_DATA == 16'h0000;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not 0");
  property p_rd_ctrl;
    $past(RD_STB) && $past(ADDR) == 5'h00 |-> (RD_DATA & 16'h3900) == ctrl_r;
  endproperty
  a_rd_ctrl: assert property (p_rd_ctrl) else $error("control readback wrong");
  property p_col_fd;
    fd && $past(fd) |-> !COL;
  endproperty
  a_col_fd: assert property (p_col_fd) else $error("collision in full duplex");
  property p_col_crs;
    COL |-> CRS;
  endproperty
  a_col_crs: assert property (p_col_crs) else $error("collision without carrier");
  property p_pd;
    pd && $past(pd) && $past(pd, 2) |-> !COL && !CRS && !RX_STB && !TX_TAKE && !LINK_UP;
  endproperty
  a_pd: assert property (p_pd) else $error("activity in power down");
  property p_rxer;
    RX_ER |-> RX_STB;
  endproperty
  a_rxer: assert property (p_rxer) else $error("error flag without nibble");
endmodule // feprd_properties
bind feprd_top feprd_properties #(.LOCK_BITS(LOCK_BITS)) u_props (
  .SYS_CLK, .RST, .ADDR, .WR_DATA, .WR_STB, .RD_STB, .RD_DATA, .TX_EN,
  .TX_STB, .RX_ER, .RX_STB, .COL, .CRS, .TX_TAKE, .LINK_UP
);

// File: tb/feprd_link_partner.sv
`timescale 1ns/10ps
// ----------------------------------------
// Remote partner sending 10 Mb/s and 100 Mb/s frames
// ----------------------------------------
module feprd_link_partner (
  output logic lclk,
  output logic ldata,
  output logic act
);
  initial begin
    lclk = 1'b0;
    ldata = 1'b0;
    act = 1'b0;
  end
  // One half-bit per rising link clock edge; the clock stands still between frames.
  task automatic half(input logic hv);
    ldata = hv;
    #62.5 lclk = 1'b1;
    #62.5 lclk = 1'b0;
  endtask
  task automatic send(input logic [3:0] n);
    for (int i = 0; i < 4; i++) begin
      half(~n[i]);
      half(n[i]);
    end
  endtask
  // 100 Mb/s groups leave MSB first, scrambled, then NRZI coded.
  logic [10:0] scr = 11'h7FF;
  logic line = 1'b0;
  task automatic grp100(input logic [4:0] g);
    logic k;
    for (int i = 4; i >= 0; i--) begin
      k = scr[10] ^ scr[8];
      scr = {scr[9:0], k};
      line = line ^ (g[i] ^ k);
      half(line);
    end
  endtask
  task automatic start();
    act = 1'b1;
  endtask
  // The released line shows the inverse level so a stale bit is never trusted.
  task automatic stop();
    act = 1'b0;
    ldata = ~ldata;
  endtask
endmodule // feprd_link_partner

// File: tb/fast_ethernet_phy_rx_decode_tb_top.sv
`timescale 1ns/10ps
// ----------------------------------------
// Bench for the receive decoder
// ----------------------------------------
module fast_ethernet_phy_rx_decode_tb_top;
  typedef struct packed {
    logic [4:0] a;
    logic [15:0] d;
    logic w;
    logic [15:0] e;
  } feprd_row_t;
  logic SYS_CLK = 1'b0;
  logic RST = 1'b1;
  logic [4:0] ADDR = 5'h00;
  logic [15:0] WR_DATA = 16'h0000;
  logic WR_STB = 1'b0;
  logic RD_STB = 1'b0;
  logic NLP_SEEN = 1'b1;
  logic MLT3_SEEN = 1'b0;
  logic FLP_SEEN = 1'b0;
  logic [3:0] LP_ABIL = 4'h0;
  logic LP_VALID = 1'b0;
  logic TX_EN = 1'b0;
  logic [3:0] TXD = 4'h0;
  logic TX_STB = 1'b0;
  logic sig_tb = 1'b0;
  logic [15:0] RD_DATA;
  logic [3:0] RXD;
  logic RX_DV, RX_ER, RX_STB, COL, CRS, TX_LINE, TX_TAKE, FLP_EMIT, LINK_UP, AN_ACK;
  wire RX_LCLK, RX_LDATA, lp_act;
  wire SIG_DET = lp_act | sig_tb;
  int mismatches = 0;
  int n_tests = 0;
  logic [15:0] v;
  logic [3:0] c;
  logic [4:0] rxq[$];
  feprd_row_t rows[8] = '{'{5'h00, 16'h0000, 1'b0, 16'h3000}, '{5'h04, 16'h0000, 1'b0, 16'h000F},
    '{5'h10, 16'h0000, 1'b0, 16'h0010}, '{5'h05, 16'h0000, 1'b0, 16'h0000},
    '{5'h02, 16'hFFFF, 1'b1, 16'h0000}, '{5'h1F, 16'hFFFF, 1'b1, 16'h0000},
    '{5'h04, 16'hFFF5, 1'b1, 16'h0005}, '{5'h05, 16'hFFFF, 1'b1, 16'h0000}};
  logic [7:0] an[5] = '{8'hF8, 8'hF5, 8'hF2, 8'h18, 8'h31};
  logic [3:0] dx[4] = '{4'h7, 4'h1, 4'hD, 4'h8};
  logic [3:0] rxn[4] = '{4'h5, 4'h5, 4'h3, 4'hC};
  logic [4:0] g100[7] = '{5'h18, 5'h11, 5'h15, 5'h1C, 5'h04, 5'h0D, 5'h07};
  logic [4:0] e100[5] = '{5'h05, 5'h05, 5'h03, 5'h0E, 5'h10};
  feprd_top #(.LOCK_BITS(11)) u_dut (.SYS_CLK, .RST, .ADDR, .WR_DATA, .WR_STB, .RD_STB,
    .RD_DATA, .RX_LCLK, .RX_LDATA, .SIG_DET, .NLP_SEEN, .MLT3_SEEN, .FLP_SEEN, .LP_ABIL,
    .LP_VALID, .TX_EN, .TXD, .TX_STB, .RXD, .RX_DV, .RX_ER, .RX_STB, .COL, .CRS, .TX_LINE,
    .TX_TAKE, .FLP_EMIT, .LINK_UP, .AN_ACK);
  feprd_link_partner u_lp (.lclk(RX_LCLK), .ldata(RX_LDATA), .act(lp_act));
  initial begin
    forever #5 SYS_CLK = ~SYS_CLK;
  end
  always @(posedge SYS_CLK) if (RX_STB === 1'b1) rxq.push_back({RX_ER, RXD});
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge SYS_CLK);
    ADDR <= a;
    WR_DATA <= d;
    WR_STB <= 1'b1;
    @(posedge SYS_CLK);
    WR_STB <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge SYS_CLK);
    ADDR <= a;
    RD_STB <= 1'b1;
    @(posedge SYS_CLK);
    RD_STB <= 1'b0;
    #1 v = RD_DATA;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge SYS_CLK);
    #1;
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // A hang costs at most a fifth of a millisecond of simulated time.
  initial begin
    #200000;
    mismatches++;
    test_done();
  end
  initial begin
    repeat (16) @(posedge SYS_CLK);
    RST <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      chk("register", rows[i].e, v);
    end
    // Normal link pulses would win by parallel detection before the exchange.
    FLP_SEEN <= 1'b1;
    NLP_SEEN <= 1'b0;
    sig_tb <= 1'b1;
    foreach (an[i]) begin
      wr(5'h04, {12'h000, an[i][7:4]});
      wr(5'h00, 16'h3000);
      settle(2);
      LP_ABIL <= an[i][3:0];
      LP_VALID <= 1'b1;
      @(posedge SYS_CLK);
      LP_VALID <= 1'b0;
      settle(8);
      rd(5'h01);
      c = an[i][7:4] & an[i][3:0];
      if (c == 4'h0) chk("an fail", 16'h0010, v & 16'h0010);
      else chk("an mode", {9'h000, c[3] | (c[1] & ~c[2]), c[3] | c[2], 5'h00}, v & 16'h0060);
      chk("an ack", 16'h0001, {15'h0000, AN_ACK});
    end
    FLP_SEEN <= 1'b0;
    NLP_SEEN <= 1'b1;
    TX_EN <= 1'b1;
    foreach (dx[i]) begin
      wr(5'h00, {7'h00, dx[i][3], 8'h00});
      sig_tb <= dx[i][2];
      settle(10);
      chk("col", {15'h0000, dx[i][1]}, {15'h0000, COL});
      chk("crs", {15'h0000, dx[i][0]}, {15'h0000, CRS});
    end
    sig_tb <= 1'b0;
    wr(5'h00, 16'h0000);
    TXD <= 4'hA;
    TX_STB <= 1'b1;
    for (int k = 0; k < 60 && TX_LINE !== 1'b1; k++) settle(1);
    TX_STB <= 1'b0;
    settle(2);
    for (int j = 0; j < 8; j++) begin
      chk("tx line", {15'h0000, TXD[j / 2] ^ ~j[0]}, {15'h0000, TX_LINE});
      settle(5);
    end
    TX_EN <= 1'b0;
    rxq.delete();
    u_lp.start();
    foreach (rxn[i]) u_lp.send(rxn[i]);
    u_lp.stop();
    settle(20);
    foreach (rxn[i]) chk("rx nibble", {12'h000, rxn[i]}, {11'h000, rxq[i]});
    wr(5'h00, 16'h2000);
    rxq.delete();
    repeat (12) u_lp.grp100(5'h1F);
    foreach (g100[i]) u_lp.grp100(g100[i]);
    repeat (4) u_lp.grp100(5'h1F);
    settle(20);
    foreach (e100[i]) chk("rx100", {11'h000, e100[i]}, {11'h000, rxq[i]});
    chk("rx100 count", 16'h0005, 16'(rxq.size()));
    chk("rx100 dv", 16'h0000, {15'h0000, RX_DV});
    rd(5'h01);
    chk("locked", 16'h0004, v & 16'h0004);
    NLP_SEEN <= 1'b0;
    settle(10);
    rd(5'h01);
    chk("reduced", 16'h0002, v & 16'h0002);
    chk("flp", 16'h0001, {15'h0000, FLP_EMIT});
    MLT3_SEEN <= 1'b1;
    settle(10);
    rd(5'h01);
    chk("awake", 16'h0000, v & 16'h0002);
    MLT3_SEEN <= 1'b0;
    wr(5'h10, 16'h0000);
    settle(10);
    rd(5'h01);
    chk("no reduce", 16'h0000, v & 16'h0002);
    NLP_SEEN <= 1'b1;
    sig_tb <= 1'b1;
    TX_EN <= 1'b1;
    wr(5'h00, 16'h0800);
    settle(10);
    chk("pd crs", 16'h0000, {15'h0000, CRS});
    rd(5'h00);
    chk("pd mgmt", 16'h0800, v & 16'h3900);
    test_done();
  end
endmodule // fast_ethernet_phy_rx_decode_tb_top
